// *** psrc_pkg.sv ***
/*
  Constants, offsets, bit positions and helper functions of the
  peripheral soft-reset control bank.
  Assumes a 32-bit APB register bus and one system clock.
*/
package psrc_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam int          PSRC_DATA_W      = 32;
  localparam int          PSRC_DEC_W       = 8;
  localparam logic [11:0] PSRC_OFS_ONE     = 12'h044;
  localparam logic [11:0] PSRC_OFS_TWO     = 12'h048;
  localparam logic [31:0] PSRC_RST_ONE     = 32'h0000_0000;
  localparam logic [31:0] PSRC_RST_TWO     = 32'h0000_0000;

  // ****************************************
  // writable fields, everything else reserved
  // ****************************************
  localparam logic [31:0] PSRC_WMASK_ONE   = 32'h0000_1017;
  localparam logic [31:0] PSRC_WMASK_TWO   = 32'h5000_007f;
  localparam int          PSRC_BIT_PHY     = 30;
  localparam int          PSRC_BIT_MAC     = 28;
  localparam int          PSRC_BIT_PORT_LO = 0;
  localparam int          PSRC_BIT_PORT_HI = 6;
  localparam int          PSRC_BIT_TWI0    = 12;
  localparam int          PSRC_BIT_SYNC_SERIAL_ZERO_RESET    = 4;
  localparam int          PSRC_BIT_ASY0    = 0;
  localparam int          PSRC_BIT_ASY1    = 1;
  localparam int          PSRC_BIT_ASY2    = 2;

  // expand apb byte strobes to a bit mask
  function automatic logic [31:0] psrc_strb_bits(input logic [3:0] strb);
    psrc_strb_bits = {{8{strb[3]}}, {8{strb[2]}},
                      {8{strb[1]}}, {8{strb[0]}}};
  endfunction

  // merge write data into a register under the given enable mask
  function automatic logic [31:0] psrc_merge(input logic [31:0] old_val,
                                             input logic [31:0] wdata,
                                             input logic [3:0]  strb,
                                             input logic [31:0] en);
    logic [31:0] hit;
    hit        = en & psrc_strb_bits(strb);
    psrc_merge = (old_val & ~hit) | (wdata & hit);
  endfunction

endpackage

// *** psrc_apb_port.sv ***
/*
  APB slave front end: decode of the two reset registers, write
  strobes and the bus answer.
  Assumes an APB master that holds its request through the access phase.
*/
module psrc_apb_port
  import psrc_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  output logic                   setup,
  output logic                   hit_one,
  output logic                   hit_two,
  output logic                   wr_one,
  output logic                   wr_two,
  output logic                   pready,
  output logic                   pslverr
);

  if (ADDR_W < PSRC_DEC_W) begin : g_chk
    $error("psrc_apb_port: ADDR_W too small for the register map");
  end

  logic access;

  // full-address compare, so unaligned addresses count as unmapped
  assign hit_one = (paddr == ADDR_W'(PSRC_OFS_ONE));
  assign hit_two = (paddr == ADDR_W'(PSRC_OFS_TWO));
  assign setup   = psel & ~penable;
  assign access  = psel & penable;
  assign wr_one  = access & pwrite & hit_one;
  assign wr_two  = access & pwrite & hit_two;
  // no wait states: every access completes in its first cycle
  assign pready  = 1'b1;
  assign pslverr = access & ~(hit_one | hit_two);

endmodule // psrc_apb_port

// *** psrc_ctl_reg.sv ***
/*
  One soft-reset control register with a fixed writable mask and a
  capability mask that gates every write.
  Assumes a synchronous active-high reset on the system clock.
*/
module psrc_ctl_reg
  import psrc_pkg::*;
#(
  parameter logic [31:0] WMASK     = 32'h0000_0000,
  parameter logic [31:0] RESET_VAL = 32'h0000_0000
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        wr,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  strb,
  input  wire logic [31:0] cap,
  output logic      [31:0] q
);

  if ((RESET_VAL & ~WMASK) != 32'h0000_0000) begin : g_chk
    $error("psrc_ctl_reg: reset value sets a reserved bit");
  end

  // reserved and absent bits never load, so reserved bits stay at zero and absent bits keep their value
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= RESET_VAL;
    end else if (wr) begin
      q <= psrc_merge(q, wdata, strb, WMASK & cap);
    end
  end

endmodule // psrc_ctl_reg

// *** psrc_top.sv ***
/*
  Peripheral soft-reset control bank: two APB registers whose bits
  hold individual peripherals in reset.
  Assumes capability masks driven from elsewhere, steady in use,
  and one 20 MHz system clock with a synchronous reset.
*/
// The APB interface to the registers was decided locally.
module psrc_top
  import psrc_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic              SYS_CLK,
  input  wire logic              RESET,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [31:0]       PWDATA,
  input  wire logic [3:0]        PSTRB,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  input  wire logic [31:0]       CAPABILITY_MASK_TWO,
  input  wire logic [31:0]       CAPABILITY_MASK_FOUR,
  output logic                   ETHERNET_PHY_RESET,
  output logic                   ETHERNET_MAC_RESET,
  output logic                   IO_PORT_A_RESET,
  output logic                   IO_PORT_B_RESET,
  output logic                   IO_PORT_C_RESET,
  output logic                   IO_PORT_D_RESET,
  output logic                   IO_PORT_E_RESET,
  output logic                   IO_PORT_F_RESET,
  output logic                   IO_PORT_G_RESET,
  output logic                   TWO_WIRE_UNIT_ZERO_RESET,
  output logic                   SYNC_SERIAL_ZERO_RESET,
  output logic                   ASYNC_SERIAL_ZERO_RESET,
  output logic                   ASYNC_SERIAL_ONE_RESET,
  output logic                   ASYNC_SERIAL_TWO_RESET
);

  // ****************************************
  // internal signals
  // ****************************************
  logic        setup;
  logic        hit_one;
  logic        hit_two;
  logic        wr_one;
  logic        wr_two;
  logic [31:0] one_q;
  logic [31:0] two_q;
  logic [31:0] rd_next;
  logic [31:0] prdata_reg;

  // ****************************************
  // bus front end
  // ****************************************
  psrc_apb_port #(
    .ADDR_W (ADDR_W)
  ) u_port (
    .psel    (PSEL),
    .penable (PENABLE),
    .pwrite  (PWRITE),
    .paddr   (PADDR),
    .setup   (setup),
    .hit_one (hit_one),
    .hit_two (hit_two),
    .wr_one  (wr_one),
    .wr_two  (wr_two),
    .pready  (PREADY),
    .pslverr (PSLVERR)
  );

  // ****************************************
  // control registers
  // ****************************************
  // register one: only its low half lives in this bank
  psrc_ctl_reg #(
    .WMASK     (PSRC_WMASK_ONE),
    .RESET_VAL (PSRC_RST_ONE)
  ) u_one (
    .clk   (SYS_CLK),
    .rst   (RESET),
    .wr    (wr_one),
    .wdata (PWDATA),
    .strb  (PSTRB),
    .cap   (CAPABILITY_MASK_TWO),
    .q     (one_q)
  );

  // register two: ethernet and io ports
  psrc_ctl_reg #(
    .WMASK     (PSRC_WMASK_TWO),
    .RESET_VAL (PSRC_RST_TWO)
  ) u_two (
    .clk   (SYS_CLK),
    .rst   (RESET),
    .wr    (wr_two),
    .wdata (PWDATA),
    .strb  (PSTRB),
    .cap   (CAPABILITY_MASK_FOUR),
    .q     (two_q)
  );

  // ****************************************
  // read path
  // ****************************************
  // reserved bits are never stored, so they read as zero
  always_comb begin
    rd_next = 32'h0000_0000;
    if (hit_one) begin
      rd_next = one_q;
    end else if (hit_two) begin
      rd_next = two_q;
    end
  end

  // data captured in setup; no write can land between setup and access
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup && !PWRITE) begin
      prdata_reg <= rd_next;
    end
  end

  assign PRDATA = prdata_reg;

  // ****************************************
  // reset lines to the peripherals
  // ****************************************
  // each line is a stored bit, so it stays asserted until cleared
  assign ETHERNET_PHY_RESET       = two_q[PSRC_BIT_PHY];
  assign ETHERNET_MAC_RESET       = two_q[PSRC_BIT_MAC];
  assign IO_PORT_A_RESET          = two_q[PSRC_BIT_PORT_LO];
  assign IO_PORT_B_RESET          = two_q[PSRC_BIT_PORT_LO + 1];
  assign IO_PORT_C_RESET          = two_q[PSRC_BIT_PORT_LO + 2];
  assign IO_PORT_D_RESET          = two_q[PSRC_BIT_PORT_LO + 3];
  assign IO_PORT_E_RESET          = two_q[PSRC_BIT_PORT_LO + 4];
  assign IO_PORT_F_RESET          = two_q[PSRC_BIT_PORT_LO + 5];
  assign IO_PORT_G_RESET          = two_q[PSRC_BIT_PORT_HI];
  assign TWO_WIRE_UNIT_ZERO_RESET = one_q[PSRC_BIT_TWI0];
  assign SYNC_SERIAL_ZERO_RESET   = one_q[PSRC_BIT_SYNC_SERIAL_ZERO_RESET];
  assign ASYNC_SERIAL_ZERO_RESET  = one_q[PSRC_BIT_ASY0];
  assign ASYNC_SERIAL_ONE_RESET   = one_q[PSRC_BIT_ASY1];
  assign ASYNC_SERIAL_TWO_RESET   = one_q[PSRC_BIT_ASY2];

  // ****************************************
  // checking helpers
  // ****************************************
  // capability bits ever seen set since reset
  logic [31:0] seen_cap_two_reg;
  logic [31:0] seen_cap_four_reg;
  logic [6:0]  ports_q;

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      seen_cap_two_reg  <= 32'h0000_0000;
      seen_cap_four_reg <= 32'h0000_0000;
    end else begin
      seen_cap_two_reg  <= seen_cap_two_reg | CAPABILITY_MASK_TWO;
      seen_cap_four_reg <= seen_cap_four_reg | CAPABILITY_MASK_FOUR;
    end
  end

  assign ports_q = {IO_PORT_G_RESET, IO_PORT_F_RESET, IO_PORT_E_RESET,
                    IO_PORT_D_RESET, IO_PORT_C_RESET, IO_PORT_B_RESET,
                    IO_PORT_A_RESET};

  default clocking cb @(posedge SYS_CLK);
  endclocking

  default disable iff (RESET);

  // ****************************************
  // named sequences
  // ****************************************
  // whole-word write accepted at register two
  sequence s_wr_two;
    PSEL && PENABLE && PWRITE && PREADY &&
    (PADDR == ADDR_W'(PSRC_OFS_TWO)) && (PSTRB == 4'hf);
  endsequence

  // whole-word write accepted at register one
  sequence s_wr_one;
    PSEL && PENABLE && PWRITE && PREADY &&
    (PADDR == ADDR_W'(PSRC_OFS_ONE)) && (PSTRB == 4'hf);
  endsequence

  // read of register two: setup then access
  sequence s_rd_two;
    (PSEL && !PENABLE && !PWRITE && (PADDR == ADDR_W'(PSRC_OFS_TWO)))
    ##1 (PSEL && PENABLE);
  endsequence

  // read of register one: setup then access
  sequence s_rd_one;
    (PSEL && !PENABLE && !PWRITE && (PADDR == ADDR_W'(PSRC_OFS_ONE)))
    ##1 (PSEL && PENABLE);
  endsequence

  // any read access cycle
  sequence s_rd_any;
    PSEL && PENABLE && !PWRITE;
  endsequence

  // write to register two that leaves byte lane zero out
  sequence s_wr_two_no_lane0;
    PSEL && PENABLE && PWRITE && PREADY &&
    (PADDR == ADDR_W'(PSRC_OFS_TWO)) && !PSTRB[0];
  endsequence

  // ****************************************
  // assertions
  // ****************************************
  AST_TWO_CAP_GATE: assert property (
    s_wr_two |=>
      ((two_q & ~$past(CAPABILITY_MASK_FOUR)) ==
       ($past(two_q) & ~$past(CAPABILITY_MASK_FOUR))))
    else $error("register two changed a bit without capability");

  AST_TWO_READBACK: assert property (
    s_rd_two |-> (PRDATA == two_q) && !PSLVERR)
    else $error("register two read returned wrong data");

  AST_TWO_RESET_ZERO: assert property (
    $past(RESET) |-> (two_q == PSRC_RST_TWO) && (one_q == PSRC_RST_ONE))
    else $error("control register not zero after reset");

  AST_PHY_SET: assert property (
    (s_wr_two ##0 (PWDATA[PSRC_BIT_PHY] &&
      CAPABILITY_MASK_FOUR[PSRC_BIT_PHY]))
    |=> ETHERNET_PHY_RESET)
    else $error("ethernet phy reset not set by write");

  AST_MAC_CLEAR: assert property (
    (s_wr_two ##0 (!PWDATA[PSRC_BIT_MAC] &&
      CAPABILITY_MASK_FOUR[PSRC_BIT_MAC]))
    |=> !ETHERNET_MAC_RESET)
    else $error("ethernet mac reset not cleared by write");

  AST_PORTS_LOAD: assert property (
    (s_wr_two ##0 (CAPABILITY_MASK_FOUR[6:0] == 7'h7f))
    |=> (ports_q == $past(PWDATA[6:0])))
    else $error("io port resets do not follow written value");

  AST_RESERVED_ZERO: assert property (
    s_rd_any |->
      ((PADDR != ADDR_W'(PSRC_OFS_ONE)) ||
       ((PRDATA & ~PSRC_WMASK_ONE) == 32'h0000_0000)) &&
      ((PADDR != ADDR_W'(PSRC_OFS_TWO)) ||
       ((PRDATA & ~PSRC_WMASK_TWO) == 32'h0000_0000)))
    else $error("reserved bit read as one");

  AST_TWI_SSI_LOAD: assert property (
    (s_wr_one ##0 (CAPABILITY_MASK_TWO[PSRC_BIT_TWI0] &&
      CAPABILITY_MASK_TWO[PSRC_BIT_SYNC_SERIAL_ZERO_RESET]))
    |=> (TWO_WIRE_UNIT_ZERO_RESET == $past(PWDATA[PSRC_BIT_TWI0])) &&
        (SYNC_SERIAL_ZERO_RESET == $past(PWDATA[PSRC_BIT_SYNC_SERIAL_ZERO_RESET])))
    else $error("two-wire or sync serial reset not loaded");

  AST_ASYNC_LOAD: assert property (
    (s_wr_one ##0 (CAPABILITY_MASK_TWO[2:0] == 3'h7))
    |=> ({ASYNC_SERIAL_TWO_RESET, ASYNC_SERIAL_ONE_RESET,
          ASYNC_SERIAL_ZERO_RESET} == $past(PWDATA[2:0])))
    else $error("async serial resets do not follow write");

  AST_ONE_CAP_GATE: assert property (
    s_wr_one |=>
      ((one_q & ~$past(CAPABILITY_MASK_TWO)) ==
       ($past(one_q) & ~$past(CAPABILITY_MASK_TWO))))
    else $error("register one changed a bit without capability");

  AST_ONE_READBACK: assert property (
    s_rd_one |-> (PRDATA == one_q) && !PSLVERR)
    else $error("register one read returned wrong data");

  AST_HOLD_IN_RESET: assert property (
    (ETHERNET_PHY_RESET && !(PSEL && PENABLE && PWRITE))
    |=> ETHERNET_PHY_RESET)
    else $error("peripheral released without a write");

  AST_ABSENT_ZERO: assert property (
    ((two_q & ~seen_cap_four_reg) == 32'h0000_0000) &&
    ((one_q & ~seen_cap_two_reg) == 32'h0000_0000))
    else $error("bit of an absent peripheral became set");

  AST_UNMAPPED_ERR: assert property (
    (PSEL && PENABLE && (PADDR != ADDR_W'(PSRC_OFS_ONE)) &&
     (PADDR != ADDR_W'(PSRC_OFS_TWO))) |-> PSLVERR)
    else $error("unmapped access not flagged");

  // ****************************************
  // further checks on bits, hold and bus answer
  // ****************************************
  // the ethernet bits both set and clear
  AST_PHY_CLEAR: assert property (
    (s_wr_two ##0 (!PWDATA[PSRC_BIT_PHY] &&
      CAPABILITY_MASK_FOUR[PSRC_BIT_PHY]))
    |=> !ETHERNET_PHY_RESET)
    else $error("ethernet phy reset not cleared by write");

  AST_MAC_SET: assert property (
    (s_wr_two ##0 (PWDATA[PSRC_BIT_MAC] &&
      CAPABILITY_MASK_FOUR[PSRC_BIT_MAC]))
    |=> ETHERNET_MAC_RESET)
    else $error("ethernet mac reset not set by write");

  // byte strobes: an absent lane leaves its bits alone
  AST_LANE_GATE: assert property (
    s_wr_two_no_lane0 |=> $stable(ports_q))
    else $error("io port resets changed with lane zero off");

  // absent units never move, whatever is written
  AST_PHY_ABSENT: assert property (
    (s_wr_two ##0 !CAPABILITY_MASK_FOUR[PSRC_BIT_PHY])
    |=> $stable(ETHERNET_PHY_RESET))
    else $error("ethernet phy reset changed without capability");

  AST_TWI_ABSENT: assert property (
    (s_wr_one ##0 !CAPABILITY_MASK_TWO[PSRC_BIT_TWI0])
    |=> $stable(TWO_WIRE_UNIT_ZERO_RESET))
    else $error("two-wire reset changed without capability");

  AST_ASYNC_ABSENT: assert property (
    (s_wr_one ##0 (CAPABILITY_MASK_TWO[2:1] == 2'h0))
    |=> $stable({ASYNC_SERIAL_TWO_RESET, ASYNC_SERIAL_ONE_RESET}))
    else $error("async serial reset changed without capability");

  // no write access means no register bit moves
  AST_REGS_HOLD: assert property (
    !(PSEL && PENABLE && PWRITE)
    |=> $stable(two_q) && $stable(one_q))
    else $error("control register changed without a write");

  // read data stands until the next read setup
  AST_RDATA_HOLD: assert property (
    !(PSEL && !PENABLE && !PWRITE) |=> $stable(PRDATA))
    else $error("read data changed outside a read setup");

  // only the two mapped words answer without error
  AST_MAPPED_OK: assert property (
    (PSEL && PENABLE && ((PADDR == ADDR_W'(PSRC_OFS_ONE)) ||
     (PADDR == ADDR_W'(PSRC_OFS_TWO)))) |-> !PSLVERR)
    else $error("mapped access flagged as error");

  AST_IDLE_NO_ERR: assert property (
    !(PSEL && PENABLE) |-> !PSLVERR)
    else $error("error answer outside an access cycle");

endmodule // psrc_top

// *** tb.sv ***
/*
  Self-checking bench for the peripheral soft-reset control bank.
  Assumes the bank answers APB through PREADY and drives each reset
  output straight from its register bit.
*/
module tb
  import psrc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ****************************************
  // clock, reset and bus signals
  // ****************************************
  logic        sys_clk;
  logic        reset;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] cap_two;
  logic [31:0] cap_four;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire         phy_rst;
  wire         mac_rst;
  wire  [6:0]  port_rst;
  wire         twi_rst;
  wire         ssi_rst;
  wire  [2:0]  asy_rst;
  logic [31:0] outs_one;
  logic [31:0] outs_two;
  logic [31:0] rd_data;
  logic        rd_err;
  int          bad_count;
  int          comparisons;

  // reset outputs gathered at their register bit positions
  assign outs_two = {1'b0, phy_rst, 1'b0, mac_rst, 21'h0, port_rst};
  assign outs_one = {19'h0, twi_rst, 7'h0, ssi_rst, 1'b0, asy_rst};

  // 20 MHz system clock
  always #25 sys_clk = ~sys_clk;

  psrc_top i_psrc_top (
    .SYS_CLK                  (sys_clk),
    .RESET                    (reset),
    .PSEL                     (psel),
    .PENABLE                  (penable),
    .PWRITE                   (pwrite),
    .PADDR                    (paddr),
    .PWDATA                   (pwdata),
    .PSTRB                    (pstrb),
    .PRDATA                   (prdata),
    .PREADY                   (pready),
    .PSLVERR                  (pslverr),
    .CAPABILITY_MASK_TWO      (cap_two),
    .CAPABILITY_MASK_FOUR     (cap_four),
    .ETHERNET_PHY_RESET       (phy_rst),
    .ETHERNET_MAC_RESET       (mac_rst),
    .IO_PORT_A_RESET          (port_rst[0]),
    .IO_PORT_B_RESET          (port_rst[1]),
    .IO_PORT_C_RESET          (port_rst[2]),
    .IO_PORT_D_RESET          (port_rst[3]),
    .IO_PORT_E_RESET          (port_rst[4]),
    .IO_PORT_F_RESET          (port_rst[5]),
    .IO_PORT_G_RESET          (port_rst[6]),
    .TWO_WIRE_UNIT_ZERO_RESET (twi_rst),
    .SYNC_SERIAL_ZERO_RESET   (ssi_rst),
    .ASYNC_SERIAL_ZERO_RESET  (asy_rst[0]),
    .ASYNC_SERIAL_ONE_RESET   (asy_rst[1]),
    .ASYNC_SERIAL_TWO_RESET   (asy_rst[2])
  );

  // ****************************************
  // reporting
  // ****************************************
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // ****************************************
  // apb master
  // ****************************************
  // one whole transfer; the wait for pready is bounded so a dead
  // slave ends the run instead of hanging it
  task automatic apb_xfer(input logic [11:0] a, input logic w,
                          input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      bad_count++;
      report_and_stop();
    end
    rd_data = prdata;
    rd_err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // outputs are looked at mid-cycle, after the access edge landed;
  // then back to a rising edge so later stimulus keeps to it
  task automatic check_outs(input logic [31:0] e1, input logic [31:0] e2);
    @(negedge sys_clk);
    check("outs_one", outs_one, e1);
    check("outs_two", outs_two, e2);
    @(posedge sys_clk);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    sys_clk = 1'b0;
    reset = 1'b1;
    {psel, penable, pwrite} = 3'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    cap_two = 32'hffff_ffff;
    cap_four = 32'hffff_ffff;
    bad_count = 0;
    comparisons = 0;
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    apb_xfer(PSRC_OFS_ONE, 1'b0, 32'h0, 4'h0);
    check("one_reset", rd_data, PSRC_RST_ONE);
    apb_xfer(PSRC_OFS_TWO, 1'b0, 32'h0, 4'h0);
    check("two_reset", rd_data, PSRC_RST_TWO);
    check_outs(32'h0, 32'h0);
    // walk a single one through every position of both registers
    for (int i = 0; i < 32; i++) begin
      apb_xfer(PSRC_OFS_TWO, 1'b1, 32'h1 << i, 4'hf);
      apb_xfer(PSRC_OFS_ONE, 1'b1, 32'h1 << i, 4'hf);
      apb_xfer(PSRC_OFS_TWO, 1'b0, 32'h0, 4'h0);
      check("two_bit", rd_data, (32'h1 << i) & 32'h5000_007f);
      apb_xfer(PSRC_OFS_ONE, 1'b0, 32'h0, 4'h0);
      check("one_bit", rd_data, (32'h1 << i) & 32'h0000_1017);
      check_outs((32'h1 << i) & 32'h0000_1017,
                 (32'h1 << i) & 32'h5000_007f);
    end
    // all ones, then clearing releases every peripheral
    apb_xfer(PSRC_OFS_TWO, 1'b1, 32'hffff_ffff, 4'hf);
    apb_xfer(PSRC_OFS_ONE, 1'b1, 32'hffff_ffff, 4'hf);
    check_outs(32'h0000_1017, 32'h5000_007f);
    apb_xfer(PSRC_OFS_TWO, 1'b1, 32'h0, 4'hf);
    apb_xfer(PSRC_OFS_ONE, 1'b1, 32'h0, 4'hf);
    check_outs(32'h0, 32'h0);
    // absent peripherals cannot be set
    cap_four <= 32'h1000_0055;
    cap_two  <= 32'h0000_0011;
    apb_xfer(PSRC_OFS_TWO, 1'b1, 32'hffff_ffff, 4'hf);
    apb_xfer(PSRC_OFS_ONE, 1'b1, 32'hffff_ffff, 4'hf);
    apb_xfer(PSRC_OFS_TWO, 1'b0, 32'h0, 4'h0);
    check("two_gated", rd_data, 32'h1000_0055);
    apb_xfer(PSRC_OFS_ONE, 1'b0, 32'h0, 4'h0);
    check("one_gated", rd_data, 32'h0000_0011);
    check_outs(32'h0000_0011, 32'h1000_0055);
    // with the mask down a write leaves the bits as they were
    cap_four <= 32'h0000_0000;
    apb_xfer(PSRC_OFS_TWO, 1'b1, 32'h0, 4'hf);
    apb_xfer(PSRC_OFS_TWO, 1'b0, 32'h0, 4'h0);
    check("two_frozen", rd_data, 32'h1000_0055);
    // byte strobes pick lanes
    cap_four <= 32'hffff_ffff;
    apb_xfer(PSRC_OFS_TWO, 1'b1, 32'h0, 4'hf);
    apb_xfer(PSRC_OFS_TWO, 1'b1, 32'hffff_ffff, 4'h1);
    apb_xfer(PSRC_OFS_TWO, 1'b0, 32'h0, 4'h0);
    check("two_lane0", rd_data, 32'h0000_007f);
    apb_xfer(PSRC_OFS_TWO, 1'b1, 32'hffff_ffff, 4'h8);
    apb_xfer(PSRC_OFS_TWO, 1'b0, 32'h0, 4'h0);
    check("two_lane3", rd_data, 32'h5000_007f);
    // read-modify-write keeps reserved bits as they were read
    apb_xfer(PSRC_OFS_TWO, 1'b1, rd_data & ~32'h0000_0001, 4'hf);
    apb_xfer(PSRC_OFS_TWO, 1'b0, 32'h0, 4'h0);
    check("two_rmw", rd_data, 32'h5000_007e);
    // unmapped and unaligned places answer with an error
    apb_xfer(12'h04c, 1'b1, 32'hffff_ffff, 4'hf);
    check("unmapped_wr_err", {31'h0, rd_err}, 32'h1);
    apb_xfer(12'h04c, 1'b0, 32'h0, 4'h0);
    check("unmapped_rd", rd_data, 32'h0);
    check("unmapped_rd_err", {31'h0, rd_err}, 32'h1);
    apb_xfer(12'h046, 1'b0, 32'h0, 4'h0);
    check("unaligned_err", {31'h0, rd_err}, 32'h1);
    apb_xfer(PSRC_OFS_TWO, 1'b0, 32'h0, 4'h0);
    check("two_kept", rd_data, 32'h5000_007e);
    check("two_ok", {31'h0, rd_err}, 32'h0);
    // a second reset in mid-run clears everything
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    check_outs(32'h0, 32'h0);
    apb_xfer(PSRC_OFS_TWO, 1'b0, 32'h0, 4'h0);
    check("two_rereset", rd_data, 32'h0);
    report_and_stop();
  end
endmodule // tb
